// file: lcs_charge_sequencer.sv
// module: top of the lithium charge sequencer: source choice, phases, safety timers, status
//
// Notes on behaviour
// - adapter has priority over USB supply
// - USB limit 100 mA, host selects 500
// - host disables charger or only USB charging
// - wait fixed delay before USB charging starts
// - adapter overvoltage inhibits charging
// - temperature fault: switch off, timers frozen
// - low cell at start: precharge, tenth current
// - precharge timer expiry: fault, detection current
// - fault cleared by reset, replacement, host
// - fast-charge timer expiry: fault, detection current
// - leaving voltage regulation resets fast timer
// - fast and taper timers off until bit5
// - taper flag starts taper timer, expiry terminates
// - current above taper restarts taper timer
// - after termination, recharge flag restarts charging
// - junction hot freezes fast and taper timers
// - termination flag ends charging at once
// - replacement low battery restarts, clears taper/term
// - supply dip resets registers; host rewrites
// - both inputs absent: sleep
// - two-bit field scales adapter current 25% steps
// - charges autonomously above undervoltage lockout
// - USB start delay 375 ms
// - temperature flag deglitched over 375 ms
`timescale 1ns/1ps
`default_nettype none
module lcs_charge_sequencer #(
    parameter int unsigned TICK_CYCLES = lcs_pkg::TICK_CYCLES,
    parameter int unsigned USB_DELAY_TICKS = lcs_pkg::USB_DELAY_TICKS,
    parameter int unsigned DEGLITCH_TICKS = lcs_pkg::DEGLITCH_TICKS,
    parameter int unsigned PRECHG_TICKS = lcs_pkg::PRECHG_TICKS,
    parameter int unsigned TAPER_TICKS = lcs_pkg::TAPER_TICKS,
    parameter int unsigned FAST_CHARGE_TICKS = lcs_pkg::FAST_CHARGE_TICKS
) (
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [3:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire lcs_pkg::lcs_flags_s FLAGS,
    output lcs_pkg::lcs_drive_s DRIVE,
    output logic CHG_DONE,
    output logic CHG_FAULT
);
    // =====================================================
    // state
    typedef struct packed {
        lcs_pkg::lcs_phase_e phase;
        logic [lcs_pkg::TICK_W-1:0] presc;
        logic tick;
        logic [15:0] usb_cnt;
        logic usb_ready;
        lcs_pkg::lcs_timer_t pre_tmr;
        lcs_pkg::lcs_timer_t fast_tmr;
        lcs_pkg::lcs_timer_t taper_tmr;
        logic taper_run;
        logic fault;
        logic taper_st;
        logic term_st;
        logic in_vreg_d;
        lcs_pkg::lcs_drive_s drive;
    } lcs_top_s;

    lcs_top_s st_r;
    lcs_top_s st_nxt;
    logic [7:0] cfg;
    logic clr_cmd;
    logic temp_ok_dg;
    logic [31:0] status;
    logic use_ac;
    logic use_usb;
    logic src_ok;
    logic run_ok;
    logic timers_en;
    logic freeze;

    function automatic lcs_pkg::lcs_timer_t bump(input lcs_pkg::lcs_timer_t t, input logic tk);
        bump = tk ? t + lcs_pkg::lcs_timer_t'(1) : t;
    endfunction

    function automatic logic reached(input lcs_pkg::lcs_timer_t t, input int unsigned lim);
        reached = (t >= lcs_pkg::lcs_timer_t'(lim));
    endfunction

    // =====================================================
    // register bus and temperature filter
    lcs_wb_regs u_regs (
        .clk(MCLK),
        .rst_n(RSTN),
        .wb_cyc(WB_CYC_I),
        .wb_stb(WB_STB_I),
        .wb_we(WB_WE_I),
        .wb_adr(WB_ADR_I),
        .wb_sel(WB_SEL_I),
        .wb_dat_w(WB_DAT_I),
        .wb_dat_r(WB_DAT_O),
        .wb_ack(WB_ACK_O),
        .status(status),
        .config_q(cfg),
        .clear_fault(clr_cmd)
    );

    // comparator chatter near the window edge must not toggle the pass switch
    lcs_deglitch #(
        .COUNT(DEGLITCH_TICKS),
        .INIT(1'b1)
    ) u_temp_dg (
        .clk(MCLK),
        .rst_n(RSTN),
        .tick(st_r.tick),
        .d(FLAGS.temp_ok),
        .q(temp_ok_dg)
    );

    // =====================================================
    // source selection and gating
    always_comb begin
        use_ac = FLAGS.ac_present && !FLAGS.ac_overvolt;
        use_usb = !FLAGS.ac_present && FLAGS.usb_present && st_r.usb_ready
            && !cfg[lcs_pkg::CFG_USB_INHIBIT_BIT];
        src_ok = (use_ac || use_usb) && !cfg[lcs_pkg::CFG_CHG_DISABLE_BIT];
        run_ok = src_ok && temp_ok_dg && !FLAGS.junc_hot;
        timers_en = cfg[lcs_pkg::CFG_TIMER_EN_BIT];
        freeze = !temp_ok_dg || FLAGS.junc_hot;
    end

    always_comb begin
        status = 32'h0000_0000;
        status[lcs_pkg::ST_FAULT_BIT] = st_r.fault;
        status[lcs_pkg::ST_TAPER_BIT] = st_r.taper_st;
        status[lcs_pkg::ST_TERM_BIT] = st_r.term_st;
        status[lcs_pkg::ST_TEMP_BIT] = !temp_ok_dg;
        status[lcs_pkg::ST_AC_SEL_BIT] = use_ac;
        status[lcs_pkg::ST_USB_SEL_BIT] = use_usb;
        status[lcs_pkg::ST_PHASE_LSB +: 3] = st_r.phase;
    end

    // =====================================================
    // sequencer
    always_comb begin
        st_nxt = st_r;
        // slow time base keeps timer widths small
        st_nxt.tick = 1'b0;
        if (st_r.presc >= lcs_pkg::TICK_W'(TICK_CYCLES - 1)) begin
            st_nxt.presc = '0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.presc = st_r.presc + lcs_pkg::TICK_W'(1);
        end

        // USB settle delay restarts whenever USB goes away
        if (!FLAGS.usb_present) begin
            st_nxt.usb_cnt = 16'h0000;
            st_nxt.usb_ready = 1'b0;
        end else if (st_r.tick && !st_r.usb_ready) begin
            if (st_r.usb_cnt >= 16'(USB_DELAY_TICKS - 1)) begin
                st_nxt.usb_ready = 1'b1;
            end else begin
                st_nxt.usb_cnt = st_r.usb_cnt + 16'h0001;
            end
        end

        st_nxt.in_vreg_d = FLAGS.in_vreg;

        // fault clear: replacement or host; a new fault in this cycle still wins below
        if (clr_cmd || FLAGS.batt_replaced) begin
            st_nxt.fault = 1'b0;
        end

        unique case (st_r.phase)
            lcs_pkg::PH_SLEEP: begin
                if (FLAGS.ac_present || FLAGS.usb_present) begin
                    st_nxt.phase = st_r.fault ? lcs_pkg::PH_FAULT : lcs_pkg::PH_IDLE;
                end
            end
            lcs_pkg::PH_IDLE: begin
                if (run_ok) begin
                    st_nxt.pre_tmr = '0;
                    st_nxt.fast_tmr = '0;
                    st_nxt.taper_tmr = '0;
                    st_nxt.taper_run = 1'b0;
                    st_nxt.phase = FLAGS.low_batt ? lcs_pkg::PH_PRECHG
                        : lcs_pkg::PH_FAST;
                end
            end
            lcs_pkg::PH_PRECHG: begin
                if (!freeze) begin
                    st_nxt.pre_tmr = bump(st_r.pre_tmr, st_r.tick);
                end
                if (!FLAGS.low_batt) begin
                    st_nxt.phase = lcs_pkg::PH_FAST;
                end else if (reached(st_r.pre_tmr, PRECHG_TICKS)) begin
                    st_nxt.fault = 1'b1;
                    st_nxt.phase = lcs_pkg::PH_FAULT;
                end
            end
            lcs_pkg::PH_FAST, lcs_pkg::PH_VREG: begin
                if (timers_en && !freeze) begin
                    st_nxt.fast_tmr = bump(st_r.fast_tmr, st_r.tick);
                end
                if (st_r.in_vreg_d && !FLAGS.in_vreg && !freeze) begin
                    st_nxt.fast_tmr = '0;
                end
                st_nxt.phase = FLAGS.in_vreg ? lcs_pkg::PH_VREG : lcs_pkg::PH_FAST;
                if (st_r.phase == lcs_pkg::PH_VREG && timers_en) begin
                    if (!FLAGS.taper) begin
                        st_nxt.taper_run = 1'b0;
                        st_nxt.taper_tmr = '0;
                    end else begin
                        st_nxt.taper_run = 1'b1;
                        if (!freeze) begin
                            st_nxt.taper_tmr = bump(st_r.taper_tmr, st_r.tick);
                        end
                    end
                end
                if (FLAGS.term && st_r.phase == lcs_pkg::PH_VREG) begin
                    st_nxt.term_st = 1'b1;
                    st_nxt.phase = lcs_pkg::PH_DONE;
                end else if (timers_en && st_r.taper_run
                        && reached(st_r.taper_tmr, TAPER_TICKS)) begin
                    st_nxt.taper_st = 1'b1;
                    st_nxt.phase = lcs_pkg::PH_DONE;
                end else if (timers_en && !st_r.taper_run
                        && reached(st_r.fast_tmr, FAST_CHARGE_TICKS)) begin
                    st_nxt.fault = 1'b1;
                    st_nxt.phase = lcs_pkg::PH_FAULT;
                end
            end
            lcs_pkg::PH_DONE: begin
                if (FLAGS.recharge) begin
                    st_nxt.fast_tmr = '0;
                    st_nxt.taper_tmr = '0;
                    st_nxt.taper_run = 1'b0;
                    st_nxt.phase = lcs_pkg::PH_FAST;
                    if (FLAGS.batt_replaced) begin
                        st_nxt.taper_st = 1'b0;
                        st_nxt.term_st = 1'b0;
                        st_nxt.phase = FLAGS.low_batt ? lcs_pkg::PH_PRECHG
                            : lcs_pkg::PH_FAST;
                        st_nxt.pre_tmr = '0;
                    end
                end
            end
            lcs_pkg::PH_FAULT: begin
                if (!st_r.fault) begin
                    st_nxt.phase = lcs_pkg::PH_IDLE;
                end
            end
            default: begin
                st_nxt.phase = lcs_pkg::PH_IDLE;
            end
        endcase

        // losing every source, or a disable, drops back; IDLE restarts the timers from zero when charging resumes
        if (!FLAGS.ac_present && !FLAGS.usb_present) begin
            st_nxt.phase = lcs_pkg::PH_SLEEP;
        end else if (!src_ok && st_r.phase != lcs_pkg::PH_FAULT
                && st_r.phase != lcs_pkg::PH_DONE) begin
            st_nxt.phase = lcs_pkg::PH_IDLE;
        end

        // output drive
        st_nxt.drive.sleep = (st_nxt.phase == lcs_pkg::PH_SLEEP);
        st_nxt.drive.ac_scale = use_ac ? cfg[lcs_pkg::CFG_SCALE_LSB +: 2] : 2'h0;
        st_nxt.drive.pass_en = 1'b0;
        st_nxt.drive.isel = lcs_pkg::ISEL_OFF;
        if (st_nxt.phase == lcs_pkg::PH_FAULT && src_ok) begin
            st_nxt.drive.isel = lcs_pkg::ISEL_DETECT;
        end else if (run_ok && st_nxt.phase == lcs_pkg::PH_PRECHG) begin
            st_nxt.drive.pass_en = 1'b1;
            st_nxt.drive.isel = lcs_pkg::ISEL_PRECHG;
        end else if (run_ok && (st_nxt.phase == lcs_pkg::PH_FAST
                || st_nxt.phase == lcs_pkg::PH_VREG)) begin
            st_nxt.drive.pass_en = 1'b1;
            if (use_ac) begin
                st_nxt.drive.isel = lcs_pkg::ISEL_AC;
            end else if (cfg[lcs_pkg::CFG_USB_500_BIT]) begin
                st_nxt.drive.isel = lcs_pkg::ISEL_USB500;
            end else begin
                st_nxt.drive.isel = lcs_pkg::ISEL_USB100;
            end
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            st_r <= '{phase: lcs_pkg::PH_SLEEP, presc: '0, tick: 1'b0,
                usb_cnt: 16'h0000, usb_ready: 1'b0, pre_tmr: '0, fast_tmr: '0,
                taper_tmr: '0, taper_run: 1'b0, fault: 1'b0, taper_st: 1'b0,
                term_st: 1'b0, in_vreg_d: 1'b0,
                drive: '{pass_en: 1'b0, isel: lcs_pkg::ISEL_OFF, ac_scale: 2'h0,
                    sleep: 1'b1}};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign DRIVE = st_r.drive;
    assign CHG_DONE = (st_r.phase == lcs_pkg::PH_DONE);
    assign CHG_FAULT = st_r.fault;
endmodule
`default_nettype wire

// file: lcs_pkg.sv
// package: register map, field layout, timing constants and carrier types for the charge sequencer
package lcs_pkg;

    // =====================================================
    // clock and time base
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned TICK_US = 1000;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;

    // =====================================================
    // delays and timers, in milliseconds or seconds, with counts in ticks
    localparam int unsigned USB_DELAY_MS = 375;
    localparam int unsigned DEGLITCH_MS = 375;
    localparam int unsigned PRECHG_TIME_S = 1800;
    localparam int unsigned TAPER_TIME_S = 1800;
    localparam int unsigned FAST_CHARGE_TIME_S = 18000;
    localparam int unsigned USB_DELAY_TICKS = USB_DELAY_MS * 1000 / TICK_US;
    localparam int unsigned DEGLITCH_TICKS = DEGLITCH_MS * 1000 / TICK_US;
    localparam int unsigned PRECHG_TICKS = PRECHG_TIME_S * 1000 / (TICK_US / 1000);
    localparam int unsigned TAPER_TICKS = TAPER_TIME_S * 1000 / (TICK_US / 1000);
    localparam int unsigned FAST_CHARGE_TICKS = FAST_CHARGE_TIME_S * 1000 / (TICK_US / 1000);
    localparam int TIMER_W = 25;
    localparam int TICK_W = 20;

    // =====================================================
    // register map (byte addresses)
    localparam logic [3:0] CONFIG_ADDR = 4'h0;
    localparam logic [3:0] STATUS_ADDR = 4'h4;
    localparam logic [3:0] COMMAND_ADDR = 4'h8;

    // charger_config_register fields
    localparam int CFG_CHG_DISABLE_BIT = 0;
    localparam int CFG_USB_INHIBIT_BIT = 1;
    localparam int CFG_USB_500_BIT = 2;
    localparam int CFG_SCALE_LSB = 3;
    localparam int CFG_TIMER_EN_BIT = 5;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // charger_status_register fields
    localparam int ST_FAULT_BIT = 0;
    localparam int ST_TAPER_BIT = 1;
    localparam int ST_TERM_BIT = 2;
    localparam int ST_TEMP_BIT = 3;
    localparam int ST_AC_SEL_BIT = 4;
    localparam int ST_USB_SEL_BIT = 5;
    localparam int ST_PHASE_LSB = 8;

    // command register: write one to clear the latched fault
    localparam int CMD_CLEAR_FAULT_BIT = 0;

    // =====================================================
    // current select codes driven to the analog regulator
    localparam logic [2:0] ISEL_OFF = 3'h0;
    localparam logic [2:0] ISEL_DETECT = 3'h1;
    localparam logic [2:0] ISEL_PRECHG = 3'h2;
    localparam logic [2:0] ISEL_USB100 = 3'h3;
    localparam logic [2:0] ISEL_USB500 = 3'h4;
    localparam logic [2:0] ISEL_AC = 3'h5;

    typedef enum logic [2:0] {
        PH_SLEEP, PH_IDLE, PH_PRECHG, PH_FAST, PH_VREG, PH_DONE, PH_FAULT
    } lcs_phase_e;

    // analog front end flags, already synchronous to MCLK
    typedef struct packed {
        logic ac_present;
        logic usb_present;
        logic ac_overvolt;
        logic low_batt;
        logic in_vreg;
        logic taper;
        logic term;
        logic recharge;
        logic temp_ok;
        logic junc_hot;
        logic batt_replaced;
    } lcs_flags_s;

    typedef struct packed {
        logic pass_en;
        logic [2:0] isel;
        logic [1:0] ac_scale;
        logic sleep;
    } lcs_drive_s;

    typedef logic [TIMER_W-1:0] lcs_timer_t;
endpackage

// file: lcs_deglitch.sv
// module: persistence filter that passes a level only after it stays put for a number of ticks
`timescale 1ns/1ps
`default_nettype none
module lcs_deglitch #(
    parameter int unsigned COUNT = lcs_pkg::DEGLITCH_TICKS,
    parameter bit INIT = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic d,
    output logic q
);
    typedef struct packed {
        logic q;
        logic [15:0] cnt;
    } lcs_dg_s;

    lcs_dg_s st_r;
    lcs_dg_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (d == st_r.q) begin
            st_nxt.cnt = 16'h0000;
        end else if (tick) begin
            if (st_r.cnt >= 16'(COUNT - 1)) begin
                st_nxt.q = d;
                st_nxt.cnt = 16'h0000;
            end else begin
                st_nxt.cnt = st_r.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{q: INIT, cnt: 16'h0000};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.q;
endmodule
`default_nettype wire

// file: lcs_wb_regs.sv
// module: classic wishbone slave holding the config register and the fault-clear command
`timescale 1ns/1ps
`default_nettype none
module lcs_wb_regs (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [3:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    input wire logic [31:0] status,
    output logic [7:0] config_q,
    output logic clear_fault
);
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [7:0] cfg;
        logic clr;
    } lcs_wb_s;

    lcs_wb_s st_r;
    lcs_wb_s st_nxt;
    logic req;

    // one wait state, so ack drops in the cycle after it was given
    assign req = wb_cyc && wb_stb && !st_r.ack;

    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = req;
        st_nxt.clr = 1'b0;
        st_nxt.rdata = 32'h0000_0000;
        if (req) begin
            unique case (wb_adr)
                lcs_pkg::CONFIG_ADDR: begin
                    st_nxt.rdata = {24'h00_0000, st_r.cfg};
                    if (wb_we && wb_sel[0]) begin
                        st_nxt.cfg = wb_dat_w[7:0];
                    end
                end
                lcs_pkg::STATUS_ADDR: begin
                    st_nxt.rdata = status;
                end
                lcs_pkg::COMMAND_ADDR: begin
                    if (wb_we && wb_sel[0]) begin
                        st_nxt.clr = wb_dat_w[lcs_pkg::CMD_CLEAR_FAULT_BIT];
                    end
                end
                default: begin
                    // unmapped: acked, reads zero, writes dropped
                    st_nxt.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{ack: 1'b0, rdata: 32'h0000_0000, cfg: lcs_pkg::CFG_RESET,
                clr: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wb_ack = st_r.ack;
    assign wb_dat_r = st_r.rdata;
    assign config_q = st_r.cfg;
    assign clear_fault = st_r.clr;
endmodule
`default_nettype wire

// file: lcs_charge_sequencer_sva.sv
// checker: port-level properties of the charge sequencer
`timescale 1ns/1ps
`default_nettype none
module lcs_charge_sequencer_sva (
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire lcs_pkg::lcs_flags_s FLAGS,
    input wire lcs_pkg::lcs_drive_s DRIVE,
    input wire logic CHG_DONE,
    input wire logic CHG_FAULT
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    // =====================================================
    // helper: cycles the cell has been out of its temperature window
    logic [4:0] cold_cnt_r;
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            cold_cnt_r <= 5'h00;
        end else if (FLAGS.temp_ok) begin
            cold_cnt_r <= 5'h00;
        end else if (cold_cnt_r != 5'h1f) begin
            cold_cnt_r <= cold_cnt_r + 5'h01;
        end
    end
    sequence s_bus_req;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    sequence s_no_supply;
        (!FLAGS.ac_present && !FLAGS.usb_present) [*2];
    endsequence
    // =====================================================
    // properties
    a_ack_latency: assert property (s_bus_req |=> WB_ACK_O)
        else $error("ack not one cycle after request");
    a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    a_rdat_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
        else $error("read data not zero outside ack");
    a_sleep_entry: assert property (s_no_supply |-> ##[0:2] DRIVE.sleep)
        else $error("no sleep with both supplies absent");
    a_usb_priority: assert property ((DRIVE.isel == lcs_pkg::ISEL_USB100 ||
        DRIVE.isel == lcs_pkg::ISEL_USB500) |-> !$past(FLAGS.ac_present) && DRIVE.ac_scale == 2'h0)
        else $error("usb current while adapter present or scaled");
    a_ovp_off: assert property ($past(FLAGS.ac_overvolt) |-> !DRIVE.pass_en)
        else $error("pass switch on under adapter overvoltage");
    a_temp_off: assert property (cold_cnt_r >= 5'd24 |-> !DRIVE.pass_en)
        else $error("pass switch on after temperature fault");
    a_fault_detect: assert property (CHG_FAULT && $past(CHG_FAULT) |->
        !DRIVE.pass_en || DRIVE.isel == lcs_pkg::ISEL_DETECT)
        else $error("fault without detection current");
    a_done_off: assert property (CHG_DONE && $past(CHG_DONE) |-> !DRIVE.pass_en)
        else $error("charging while terminated");
endmodule
`default_nettype wire

// file: lcs_supply_model.sv
// partner model: supplies, cell and front-end comparator flags
`timescale 1ns/1ps
`default_nettype none
module lcs_supply_model (
    input wire logic clk,
    input wire lcs_pkg::lcs_flags_s want,
    input wire lcs_pkg::lcs_drive_s drive,
    output lcs_pkg::lcs_flags_s flags
);
    // comparators settle between edges, so flags move just after a rising edge
    always_ff @(posedge clk) begin
        flags <= want;
        // the cell cannot sit in voltage regulation without charge current
        flags.in_vreg <= want.in_vreg && drive.pass_en;
    end
endmodule
`default_nettype wire

// file: lcs_charge_sequencer_tb_top.sv
// testbench: directed scenarios for the charge sequencer
`timescale 1ns/1ps
`default_nettype none
module lcs_charge_sequencer_tb_top;
    localparam int TK = 4;
    localparam int PT = 20;
    localparam int TT = 20;
    localparam int FT = 40;
    logic MCLK, RSTN, cyc, stb, we, ack, done, fault;
    logic [3:0] adr, sel;
    logic [31:0] wdat, rdat, q;
    lcs_pkg::lcs_flags_s want, flags;
    lcs_pkg::lcs_drive_s drv;
    int error_cnt = 0;
    int num_checks = 0;
    lcs_charge_sequencer #(.TICK_CYCLES(TK), .USB_DELAY_TICKS(3), .DEGLITCH_TICKS(3),
        .PRECHG_TICKS(PT), .TAPER_TICKS(TT), .FAST_CHARGE_TICKS(FT)) dut (.MCLK(MCLK),
        .RSTN(RSTN), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .FLAGS(flags),
        .DRIVE(drv), .CHG_DONE(done), .CHG_FAULT(fault));
    lcs_supply_model far (.clk(MCLK), .want(want), .drive(drv), .flags(flags));
    // =====================================================
    // common tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge MCLK);
    endtask
    // called just after a rising edge; holds the request until ack is sampled
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge MCLK);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 50) begin
            error_cnt++;
            report_and_stop();
        end
        @(posedge MCLK);
    endtask
    // =====================================================
    // scenarios
    task automatic t_adapter;
        want.ac_present <= 1'b1;
        want.usb_present <= 1'b1;
        tk(4);
        check(32'(drv.isel), 32'(lcs_pkg::ISEL_AC));
        bus(1'b1, lcs_pkg::CONFIG_ADDR, 32'h18);
        check(32'(drv.ac_scale), 32'h3);
        want.ac_overvolt <= 1'b1;
        tk(3);
        check(32'(drv.pass_en), 32'h0);
        want.ac_overvolt <= 1'b0;
        want.temp_ok <= 1'b0;
        tk(4);
        check(32'(drv.pass_en), 32'h1);
        tk(20);
        check(32'(drv.pass_en), 32'h0);
        want.temp_ok <= 1'b1;
        tk(24);
        check(32'(drv.pass_en), 32'h1);
        want.junc_hot <= 1'b1;
        tk(3);
        check(32'(drv.pass_en), 32'h0);
        want.junc_hot <= 1'b0;
    endtask
    task automatic t_usb;
        int n;
        n = 0;
        want.ac_present <= 1'b0;
        want.usb_present <= 1'b0;
        tk(4);
        check(32'(drv.sleep), 32'h1);
        want.usb_present <= 1'b1;
        do begin
            @(posedge MCLK);
            n++;
        end while (drv.isel !== lcs_pkg::ISEL_USB100 && n < 40);
        check(32'(n >= 8 && n <= 20), 32'h1);
        bus(1'b1, lcs_pkg::CONFIG_ADDR, 32'h1c);
        check(32'(drv.isel), 32'(lcs_pkg::ISEL_USB500));
        check(32'(drv.ac_scale), 32'h0);
        bus(1'b1, lcs_pkg::CONFIG_ADDR, 32'h02);
        check(32'(drv.pass_en), 32'h0);
        want.ac_present <= 1'b1;
        tk(4);
        check(32'(drv.isel), 32'(lcs_pkg::ISEL_AC));
        bus(1'b1, lcs_pkg::CONFIG_ADDR, 32'h01);
        check(32'(drv.pass_en), 32'h0);
        bus(1'b1, lcs_pkg::CONFIG_ADDR, 32'h00);
    endtask
    task automatic t_precharge;
        want.low_batt <= 1'b1;
        RSTN <= 1'b0;
        tk(2);
        RSTN <= 1'b1;
        tk(4);
        check(32'(drv.isel), 32'(lcs_pkg::ISEL_PRECHG));
        tk(PT * TK / 2);
        check(32'(fault), 32'h0);
        tk(PT * TK / 2 + 12);
        check(32'(fault), 32'h1);
        check(32'(drv.isel), 32'(lcs_pkg::ISEL_DETECT));
        want.low_batt <= 1'b0;
        bus(1'b0, lcs_pkg::STATUS_ADDR, 32'h0);
        check(q & 32'h1, 32'h1);
        bus(1'b1, lcs_pkg::COMMAND_ADDR, 32'h1);
        tk(2);
        check(32'(fault), 32'h0);
    endtask
    task automatic t_timers;
        tk(FT * TK + 16);
        check(32'(fault), 32'h0);
        bus(1'b1, lcs_pkg::CONFIG_ADDR, 32'h20);
        tk(FT * TK + 16);
        check(32'(fault), 32'h1);
        want.batt_replaced <= 1'b1;
        tk(1);
        want.batt_replaced <= 1'b0;
        tk(4);
        check(32'(fault), 32'h0);
        want.in_vreg <= 1'b1;
        want.taper <= 1'b1;
        tk(TT * TK / 2);
        want.taper <= 1'b0;
        tk(2);
        want.taper <= 1'b1;
        tk(TT * TK - 8);
        check(32'(done), 32'h0);
        tk(24);
        check(32'(done), 32'h1);
        bus(1'b0, lcs_pkg::STATUS_ADDR, 32'h0);
        check(q & 32'h2, 32'h2);
        want.recharge <= 1'b1;
        tk(3);
        check(32'(drv.pass_en), 32'h1);
        want.recharge <= 1'b0;
        want.term <= 1'b1;
        tk(5);
        check(32'(done), 32'h1);
        bus(1'b0, lcs_pkg::STATUS_ADDR, 32'h0);
        check(q & 32'h4, 32'h4);
        want.term <= 1'b0;
        want.batt_replaced <= 1'b1;
        want.recharge <= 1'b1;
        tk(3);
        check(32'(done), 32'h0);
        bus(1'b0, lcs_pkg::STATUS_ADDR, 32'h0);
        check(q & 32'h6, 32'h0);
    endtask
    // =====================================================
    // clock, watchdog and main sequence
    initial begin
        MCLK = 1'b0;
        forever #4 MCLK = ~MCLK;
    end
    initial begin
        tk(20000);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        RSTN = 1'b0;
        {cyc, stb, we, adr, wdat} = '0;
        sel = 4'hf;
        want = '0;
        want.temp_ok = 1'b1;
        tk(20);
        RSTN <= 1'b1;
        tk(1);
        bus(1'b0, lcs_pkg::CONFIG_ADDR, 32'h0);
        check(q, 32'h0);
        check(32'(drv.sleep), 32'h1);
        t_adapter();
        t_usb();
        t_precharge();
        t_timers();
        report_and_stop();
    end
endmodule
bind lcs_charge_sequencer lcs_charge_sequencer_sva u_sva (.MCLK(MCLK), .RSTN(RSTN),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .FLAGS(FLAGS), .DRIVE(DRIVE), .CHG_DONE(CHG_DONE), .CHG_FAULT(CHG_FAULT));
`default_nettype wire
